// *** hdl/oam_operand_gen.sv ***
// Purpose: operand address generation between decode and memory port
// Assumes: register values and program counter arrive with the request
// Notes: byte operands are read as their whole containing word

`timescale 1ns/1ps

module oam_operand_gen (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input oam_pkg::oam_req_s req,
    output logic req_ready_q,
    output logic fetch_req_q,
    output oam_pkg::oam_addr_t fetch_addr_q,
    input wire logic fetch_ack,
    input oam_pkg::oam_word_t fetch_data,
    output logic mem_req_q,
    output logic mem_we_q,
    output oam_pkg::oam_addr_t mem_addr_q,
    output oam_pkg::oam_word_t mem_wdata_q,
    input wire logic mem_ack,
    input oam_pkg::oam_word_t mem_rdata,
    output logic res_valid_q,
    output oam_pkg::oam_res_s res_q,
    input wire logic wr_valid,
    input oam_pkg::oam_addr_t wr_data,
    output logic reg_we_q,
    output logic [3:0] reg_idx_q,
    output oam_pkg::oam_addr_t reg_val_q,
    output logic pc_we_q,
    output oam_pkg::oam_addr_t pc_val_q
);
    import oam_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_EXT, ST_FSRC, ST_FDST, ST_SRC, ST_SWAIT, ST_RES, ST_WAIT, ST_DWR
    } oam_st_e;

    oam_st_e st_q;
    oam_req_s rq_q;
    oam_addr_t pc_q;
    oam_word_t sword_q;
    oam_word_t dword_q;
    oam_addr_t src_data_q;
    oam_addr_t wdata_q;
    logic seq_start_q;
    logic seq_we_q;

    oam_addr_t src_addr;
    oam_addr_t src_imm;
    oam_addr_t dst_addr;
    oam_addr_t ptr_next;
    logic [2:0] length;
    logic src_need;
    logic dst_need;
    logic illegal;
    logic seq_done;
    oam_addr_t seq_rdata;

    // ----------------
    // decode helpers
    // ----------------
    wire accept = req_valid && req_ready_q;
    wire fetch_done = fetch_req_q && fetch_ack;
    wire src_mem = (rq_q.smode == OAM_S_IND) || (rq_q.smode == OAM_S_AINC)
                 || (rq_q.smode == OAM_S_ABS);
    wire dst_mem = (rq_q.dmode == OAM_D_IDX) || (rq_q.dmode == OAM_D_ABS);
    wire is_ainc = rq_q.smode == OAM_S_AINC;
    wire two_words = rq_q.size == OAM_SZ_A;
    wire [19:0] seq_addr = seq_we_q ? dst_addr : src_addr;
    wire [19:0] src_direct = (rq_q.smode == OAM_S_REG) ? rq_q.src_ptr : src_imm;
    wire [19:0] pc_next = pc_q + OAM_PC_STEP;

    // ----------------
    // address arithmetic
    // ----------------
    oam_addr_calc u_calc (
        .req(rq_q),
        .src_word(sword_q),
        .dst_word(dword_q),
        .src_addr(src_addr),
        .src_imm(src_imm),
        .dst_addr(dst_addr),
        .ptr_next(ptr_next),
        .length(length),
        .src_need(src_need),
        .dst_need(dst_need),
        .illegal(illegal)
    );

    // ----------------
    // memory word sequencer
    // ----------------
    oam_mem_seq u_seq (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(seq_start_q),
        .we(seq_we_q),
        .two(two_words),
        .addr(seq_addr),
        .wdata(wdata_q),
        .mem_req_q(mem_req_q),
        .mem_we_q(mem_we_q),
        .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata),
        .done_q(seq_done),
        .rdata_q(seq_rdata)
    );

    // ----------------
    // control sequence
    // ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            rq_q <= '0;
            pc_q <= OAM_ADDR_RST;
            sword_q <= OAM_WORD_RST;
            dword_q <= OAM_WORD_RST;
            src_data_q <= OAM_ADDR_RST;
            wdata_q <= OAM_ADDR_RST;
            seq_start_q <= 1'b0;
            seq_we_q <= 1'b0;
            req_ready_q <= 1'b1;
            fetch_req_q <= 1'b0;
            fetch_addr_q <= OAM_ADDR_RST;
            res_valid_q <= 1'b0;
            res_q <= '0;
            reg_we_q <= 1'b0;
            reg_idx_q <= OAM_HI_ZERO;
            reg_val_q <= OAM_ADDR_RST;
            pc_we_q <= 1'b0;
            pc_val_q <= OAM_ADDR_RST;
        end else begin
            seq_start_q <= 1'b0;
            res_valid_q <= 1'b0;
            reg_we_q <= 1'b0;
            pc_we_q <= 1'b0;
            unique case (st_q)
                ST_IDLE: if (accept) begin
                    rq_q <= req; // RULE17
                    pc_q <= req.pc; // RULE15
                    req_ready_q <= 1'b0;
                    st_q <= req.is_ext ? ST_EXT : ST_FSRC;
                end
                ST_EXT: st_q <= ST_FSRC; // RULE14
                ST_FSRC: begin
                    if (!src_need) begin
                        st_q <= ST_FDST;
                    end else if (fetch_done) begin
                        sword_q <= fetch_data; // RULE9 RULE10
                        pc_q <= pc_next; // RULE8
                        fetch_req_q <= 1'b0;
                        st_q <= ST_FDST;
                    end else begin
                        fetch_req_q <= 1'b1;
                        fetch_addr_q <= pc_q;
                    end
                end
                ST_FDST: begin
                    if (!dst_need) begin
                        st_q <= ST_SRC;
                    end else if (fetch_done) begin
                        dword_q <= fetch_data;
                        pc_q <= pc_next;
                        fetch_req_q <= 1'b0;
                        st_q <= ST_SRC;
                    end else begin
                        fetch_req_q <= 1'b1;
                        fetch_addr_q <= pc_q;
                    end
                end
                ST_SRC: begin
                    if (src_mem && !illegal) begin
                        seq_start_q <= 1'b1;
                        seq_we_q <= 1'b0;
                        st_q <= ST_SWAIT;
                    end else begin
                        src_data_q <= src_direct;
                        st_q <= ST_RES;
                    end
                end
                ST_SWAIT: if (seq_done) begin
                    src_data_q <= seq_rdata; // RULE13
                    reg_we_q <= is_ainc; // RULE5
                    reg_idx_q <= rq_q.src_reg;
                    reg_val_q <= ptr_next; // RULE5
                    st_q <= ST_RES;
                end
                ST_RES: begin
                    res_valid_q <= 1'b1;
                    res_q.src_addr <= src_addr;
                    res_q.src_data <= src_data_q;
                    res_q.dst_addr <= dst_addr; // RULE6
                    res_q.dst_mem <= dst_mem;
                    res_q.length <= length; // RULE12
                    res_q.illegal <= illegal; // RULE16
                    pc_we_q <= 1'b1;
                    pc_val_q <= pc_q; // RULE8
                    if (dst_mem && !illegal) begin
                        st_q <= ST_WAIT;
                    end else begin
                        req_ready_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                ST_WAIT: if (wr_valid) begin
                    wdata_q <= wr_data;
                    seq_start_q <= 1'b1;
                    seq_we_q <= 1'b1; // RULE13
                    st_q <= ST_DWR;
                end
                ST_DWR: if (seq_done) begin
                    req_ready_q <= 1'b1;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

endmodule // oam_operand_gen

// *** inc/oam_pkg.sv ***
// Purpose: constants, types and helpers for the operand address generator
// Assumes: one clock, asynchronous active-high reset
// Notes: 20-bit addresses, 16-bit memory words
//
// What this block does
// RULE1: extended absolute address: extension word gives top 4 bits, next word low 16
// RULE2: absolute address is offset from zero; allowed for source and destination
// RULE3: indirect register reads source at 20-bit pointer; pointer register unchanged
// RULE4: indirect register only for source; destination uses indexed with zero offset
// RULE5: autoincrement adds 1 byte, 2 word, 4 address-word right after source access
// RULE6: same register as destination: destination uses already incremented pointer
// RULE7: autoincrement only for source, always full 20-bit addresses
// RULE8: immediate is autoincrement through program counter; counter steps 2 always
// RULE9: base immediate takes 8/16-bit constant from next word, 16-bit destination
// RULE10: extended immediate builds 20-bit constant from extension plus next word
// RULE11: base immediate takes two or three words, one less with constant generator
// RULE12: indirect modes take one to three words; extended absolute/immediate three or four
// RULE13: address-word operands occupy two consecutive words from the operand address
// RULE14: extended forms carry an extension word costing space and extra cycles
// RULE15: base instructions run anywhere in the 1MB space
// RULE16: base set holds 27 implemented instructions; others are emulations
// RULE17: extension high bits latched before following word is fetched

package oam_pkg;

    // ----------------
    // constants
    // ----------------
    localparam int OAM_AW = 20;
    localparam int OAM_DW = 16;
    localparam logic [19:0] OAM_INC_B = 20'h00001;
    localparam logic [19:0] OAM_INC_W = 20'h00002;
    localparam logic [19:0] OAM_INC_A = 20'h00004;
    localparam logic [19:0] OAM_PC_STEP = 20'h00002;
    localparam logic [19:0] OAM_WORD_STEP = 20'h00002;
    localparam logic [4:0] OAM_NUM_BASE_OPS = 5'h1B;
    localparam logic [19:0] OAM_ADDR_RST = 20'h00000;
    localparam logic [15:0] OAM_WORD_RST = 16'h0000;
    localparam logic [3:0] OAM_HI_ZERO = 4'h0;
    localparam logic [2:0] OAM_LEN_ONE = 3'h1;

    // ----------------
    // types
    // ----------------
    typedef logic [19:0] oam_addr_t;
    typedef logic [15:0] oam_word_t;

    typedef enum logic [2:0] {
        OAM_S_REG, OAM_S_IND, OAM_S_AINC, OAM_S_IMM, OAM_S_ABS, OAM_S_CG
    } oam_smode_e;

    typedef enum logic [1:0] {
        OAM_D_REG, OAM_D_IDX, OAM_D_ABS, OAM_D_IND
    } oam_dmode_e;

    typedef enum logic [1:0] {
        OAM_SZ_B, OAM_SZ_W, OAM_SZ_A
    } oam_size_e;

    typedef struct packed {
        logic is_ext;
        logic [3:0] src_hi;
        logic [3:0] dst_hi;
        oam_smode_e smode;
        oam_dmode_e dmode;
        oam_size_e size;
        logic [4:0] op_idx;
        logic [3:0] src_reg;
        logic [3:0] dst_reg;
        oam_addr_t src_ptr;
        oam_addr_t dst_ptr;
        oam_addr_t pc;
        oam_addr_t cg_val;
    } oam_req_s;

    typedef struct packed {
        oam_addr_t src_addr;
        oam_addr_t src_data;
        oam_addr_t dst_addr;
        logic dst_mem;
        logic [2:0] length;
        logic illegal;
    } oam_res_s;

    // ----------------
    // helpers
    // ----------------
    function automatic oam_addr_t oam_join(input logic [3:0] hi, input oam_word_t lo);
        return {hi, lo};
    endfunction

    function automatic oam_addr_t oam_step(input oam_size_e sz);
        oam_addr_t s;
        s = OAM_INC_W;
        if (sz == OAM_SZ_B) begin
            s = OAM_INC_B;
        end else if (sz == OAM_SZ_A) begin
            s = OAM_INC_A;
        end
        return s;
    endfunction

endpackage

// *** hdl/oam_addr_calc.sv ***
// Purpose: effective address and constant computation
// Assumes: inputs held while results are used
// Notes: purely combinational

`timescale 1ns/1ps

module oam_addr_calc (
    input oam_pkg::oam_req_s req,
    input oam_pkg::oam_word_t src_word,
    input oam_pkg::oam_word_t dst_word,
    output oam_pkg::oam_addr_t src_addr,
    output oam_pkg::oam_addr_t src_imm,
    output oam_pkg::oam_addr_t dst_addr,
    output oam_pkg::oam_addr_t ptr_next,
    output logic [2:0] length,
    output logic src_need,
    output logic dst_need,
    output logic illegal
);
    import oam_pkg::*;

    wire [3:0] hi_s;
    wire [3:0] hi_d;
    wire same_reg;
    wire [19:0] dst_base;
    wire [19:0] dst_index;

    // ----------------
    // source side
    // ----------------
    assign hi_s = req.is_ext ? req.src_hi : OAM_HI_ZERO; // RULE17
    assign src_need = (req.smode == OAM_S_IMM) || (req.smode == OAM_S_ABS);
    assign ptr_next = req.src_ptr + oam_step(req.size); // RULE5
    assign src_addr = (req.smode == OAM_S_ABS) ? oam_join(hi_s, src_word) // RULE1 RULE2
                    : req.src_ptr; // RULE3 RULE7
    assign src_imm = (req.smode == OAM_S_IMM) ? oam_join(hi_s, src_word) // RULE9 RULE10
                   : req.cg_val; // RULE11

    // ----------------
    // destination side
    // ----------------
    assign hi_d = req.is_ext ? req.dst_hi : OAM_HI_ZERO;
    assign dst_need = (req.dmode == OAM_D_IDX) || (req.dmode == OAM_D_ABS);
    assign same_reg = (req.smode == OAM_S_AINC) && (req.src_reg == req.dst_reg);
    assign dst_base = same_reg ? ptr_next : req.dst_ptr; // RULE6
    assign dst_index = req.is_ext ? {req.dst_hi, dst_word} : {{4{dst_word[15]}}, dst_word};
    assign dst_addr = (req.dmode == OAM_D_ABS) ? oam_join(hi_d, dst_word) // RULE2
                    : dst_base + dst_index;

    // ----------------
    // length and legality
    // ----------------
    assign length = OAM_LEN_ONE + {2'b00, req.is_ext} // RULE11 RULE12 RULE14
                  + {2'b00, src_need} + {2'b00, dst_need};
    assign illegal = (req.dmode == OAM_D_IND) // RULE4
                   || (req.op_idx >= OAM_NUM_BASE_OPS); // RULE16

endmodule // oam_addr_calc

// *** hdl/oam_mem_seq.sv ***
// Purpose: one- or two-word operand access on the memory port
// Assumes: memory acknowledges with a one-cycle pulse while request is high
// Notes: second word holds address bits 19:16 in its low nibble

`timescale 1ns/1ps

module oam_mem_seq (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic we,
    input wire logic two,
    input oam_pkg::oam_addr_t addr,
    input oam_pkg::oam_addr_t wdata,
    output logic mem_req_q,
    output logic mem_we_q,
    output oam_pkg::oam_addr_t mem_addr_q,
    output oam_pkg::oam_word_t mem_wdata_q,
    input wire logic mem_ack,
    input oam_pkg::oam_word_t mem_rdata,
    output logic done_q,
    output oam_pkg::oam_addr_t rdata_q
);
    import oam_pkg::*;

    typedef enum logic [1:0] {SQ_IDLE, SQ_LO, SQ_HI} oam_sq_e;
    oam_sq_e st_q;
    logic two_q;
    logic [3:0] whi_q;

    // ----------------
    // word sequencer
    // ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= SQ_IDLE;
            two_q <= 1'b0;
            whi_q <= OAM_HI_ZERO;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= OAM_ADDR_RST;
            mem_wdata_q <= OAM_WORD_RST;
            done_q <= 1'b0;
            rdata_q <= OAM_ADDR_RST;
        end else begin
            done_q <= 1'b0;
            unique case (st_q)
                SQ_IDLE: if (start) begin
                    st_q <= SQ_LO;
                    two_q <= two;
                    whi_q <= wdata[19:16];
                    mem_req_q <= 1'b1;
                    mem_we_q <= we;
                    mem_addr_q <= addr;
                    mem_wdata_q <= wdata[15:0];
                end
                SQ_LO: if (mem_ack) begin
                    rdata_q <= {OAM_HI_ZERO, mem_rdata};
                    if (two_q) begin
                        st_q <= SQ_HI;
                        mem_addr_q <= mem_addr_q + OAM_WORD_STEP; // RULE13
                        mem_wdata_q <= {12'h000, whi_q};
                    end else begin
                        st_q <= SQ_IDLE;
                        mem_req_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
                SQ_HI: if (mem_ack) begin
                    rdata_q[19:16] <= mem_rdata[3:0]; // RULE13
                    st_q <= SQ_IDLE;
                    mem_req_q <= 1'b0;
                    done_q <= 1'b1;
                end
                default: st_q <= SQ_IDLE;
            endcase
        end
    end

endmodule // oam_mem_seq

// *** bench/oam_operand_gen_props.sv ***
// Purpose: port-level properties of the operand address generator
// Assumes: request fields held by the driver until the answer
// Notes: bound to the top module after endmodule

`timescale 1ns/1ps

module oam_operand_gen_props (
    input logic ref_clk,
    input logic rst,
    input logic req_valid,
    input oam_pkg::oam_req_s req,
    input logic req_ready_q,
    input logic fetch_req_q,
    input oam_pkg::oam_addr_t fetch_addr_q,
    input logic fetch_ack,
    input logic mem_req_q,
    input oam_pkg::oam_addr_t mem_addr_q,
    input logic mem_ack,
    input logic res_valid_q,
    input oam_pkg::oam_res_s res_q,
    input logic reg_we_q,
    input logic [3:0] reg_idx_q,
    input oam_pkg::oam_addr_t reg_val_q,
    input logic pc_we_q,
    input oam_pkg::oam_addr_t pc_val_q
);
    import oam_pkg::*;
    // ----------------
    // helpers
    // ----------------
    logic [2:0] fcnt_q;
    oam_addr_t ptr_step;
    wire take = req_valid && req_ready_q;
    assign ptr_step = (req.size == OAM_SZ_B) ? 20'h00001 :
                      (req.size == OAM_SZ_A) ? 20'h00004 : 20'h00002;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fcnt_q <= 3'h0;
        end else begin
            fcnt_q <= take ? 3'h0 : fcnt_q + {2'h0, fetch_req_q && fetch_ack};
        end
    end
    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    take_busy_a: assert property (take |=> !req_ready_q)
        else $error("ready held");
    fetch_hold_a: assert property (fetch_req_q && !fetch_ack
        |=> fetch_req_q && $stable(fetch_addr_q)) else $error("fetch not held");
    fetch_drop_a: assert property (fetch_req_q && fetch_ack |=> !fetch_req_q)
        else $error("fetch not dropped");
    mem_hold_a: assert property (mem_req_q && !mem_ack
        |=> mem_req_q && $stable(mem_addr_q)) else $error("mem not held");
    word_pair_a: assert property (mem_req_q && mem_ack ##1 mem_req_q
        |-> mem_addr_q == $past(mem_addr_q) + 20'h2) else $error("word step wrong");
    ptr_step_a: assert property (reg_we_q
        |-> reg_val_q == req.src_ptr + ptr_step && reg_idx_q == req.src_reg)
        else $error("pointer wrong");
    ind_keep_a: assert property (reg_we_q |-> req.smode == OAM_S_AINC)
        else $error("pointer written");
    res_pulse_a: assert property (res_valid_q |=> !res_valid_q)
        else $error("result too long");
    pc_step_a: assert property (pc_we_q
        |-> pc_val_q == req.pc + {16'h0000, fcnt_q, 1'b0}) else $error("pc step wrong");
    imm_join_a: assert property (res_valid_q && req.smode == OAM_S_IMM
        |-> res_q.src_data[19:16] == (req.is_ext ? req.src_hi : 4'h0))
        else $error("imm high wrong");
    abs_zero_a: assert property (res_valid_q && req.smode == OAM_S_ABS
        && !res_q.illegal |-> res_q.src_addr[19:16] == (req.is_ext ? req.src_hi : 4'h0))
        else $error("abs high wrong");
    bad_op_a: assert property (res_valid_q
        && (req.dmode == OAM_D_IND || req.op_idx > 5'h1A) |-> res_q.illegal)
        else $error("illegal not flagged");
    cover property (reg_we_q);
    cover property (res_valid_q && res_q.illegal);
    cover property (mem_req_q && mem_ack ##1 mem_req_q);
endmodule // oam_operand_gen_props

bind oam_operand_gen oam_operand_gen_props i_oam_operand_gen_props (.ref_clk, .rst, .req_valid,
    .req, .req_ready_q, .fetch_req_q, .fetch_addr_q, .fetch_ack, .mem_req_q, .mem_addr_q,
    .mem_ack, .res_valid_q, .res_q, .reg_we_q, .reg_idx_q, .reg_val_q, .pc_we_q, .pc_val_q);

// *** bench/oam_operand_gen_tb_top.sv ***
// Purpose: self-checking bench for the operand address generator
// Assumes: fetch and memory ports answered one cycle after each request
// Notes: one task per scenario

`timescale 1ns/1ps

module oam_operand_gen_tb_top;
    import oam_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    oam_req_s req = '0;
    logic fetch_ack = 1'b0;
    oam_word_t fetch_data = 16'h0000;
    logic mem_ack = 1'b0;
    oam_word_t mem_rdata = 16'h0000;
    logic wr_valid = 1'b0;
    oam_addr_t wr_data = 20'h00000;
    logic req_ready_q, fetch_req_q, mem_req_q, mem_we_q, res_valid_q, reg_we_q, pc_we_q;
    logic f_go, m_go;
    oam_addr_t fetch_addr_q, mem_addr_q, reg_val_q, pc_val_q, reg_got, pc_got;
    oam_word_t mem_wdata_q;
    oam_res_s res_q, res_got;
    logic [3:0] reg_idx_q;
    oam_word_t fq[$], rq[$];
    oam_addr_t fa[$];
    logic [36:0] ma[$];
    int n_reg, err_total, num_checks;

    always #4 ref_clk = ~ref_clk;

    oam_operand_gen i_oam_operand_gen (.*);

    // ----------------
    // port responders and monitor
    // ----------------
    always @(posedge ref_clk) begin
        f_go = fetch_req_q === 1'b1 && !fetch_ack && fq.size() > 0;
        m_go = mem_req_q === 1'b1 && !mem_ack;
        fetch_ack <= f_go;
        mem_ack <= m_go;
        if (f_go) begin
            fa.push_back(fetch_addr_q);
            fetch_data <= fq.pop_front();
        end else begin
            fetch_data <= ~fetch_data;
        end
        if (m_go) begin
            ma.push_back({mem_we_q, mem_addr_q, mem_wdata_q});
        end
        if (m_go && mem_we_q === 1'b0 && rq.size() > 0) begin
            mem_rdata <= rq.pop_front();
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (res_valid_q === 1'b1) begin
            res_got <= res_q;
        end
        if (reg_we_q === 1'b1) begin
            n_reg <= n_reg + 1;
            reg_got <= reg_val_q;
        end
        if (pc_we_q === 1'b1) begin
            pc_got <= pc_val_q;
        end
    end

    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic oam_req_s base();
        oam_req_s r;
        r = '0;
        r.smode = OAM_S_REG;
        r.dmode = OAM_D_REG;
        r.size = OAM_SZ_W;
        r.op_idx = 5'h01;
        r.pc = 20'h21036;
        return r;
    endfunction

    task automatic run(input oam_req_s r, input logic wr, input oam_addr_t wd);
        int n;
        fa.delete();
        ma.delete();
        n_reg = 0;
        @(posedge ref_clk);
        req <= r;
        req_valid <= 1'b1;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        n = 0;
        do @(negedge ref_clk); while (res_valid_q !== 1'b1 && ++n < 200);
        chk("answer", 20'h00001, {19'h0, res_valid_q});
        if (wr) begin
            @(posedge ref_clk);
            wr_valid <= 1'b1;
            wr_data <= wd;
            @(posedge ref_clk);
            wr_valid <= 1'b0;
        end
        n = 0;
        while (req_ready_q !== 1'b1 && ++n < 200) @(negedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // ----------------
    // scenarios
    // ----------------
    task automatic t_imm();
        oam_req_s r;
        for (int e = 0; e < 2; e++) begin
            r = base();
            r.is_ext = e[0];
            r.src_hi = 4'h2;
            r.smode = OAM_S_IMM;
            r.size = e ? OAM_SZ_A : OAM_SZ_W;
            r.pc = 20'h4F000;
            fq = '{16'h3456};
            run(r, 1'b0, 20'h00000);
            chk("fetch addr", r.pc, fa[0]);
            chk("pc step", r.pc + 20'h00002, pc_got);
            chk("imm value", e ? 20'h23456 : 20'h03456, res_got.src_data);
            chk("imm length", e ? 20'h00003 : 20'h00002, 20'(res_got.length));
        end
        r = base();
        r.smode = OAM_S_CG;
        r.cg_val = 20'h00008;
        run(r, 1'b0, 20'h00000);
        chk("cg value", 20'h00008, res_got.src_data);
        chk("cg length", 20'h00001, 20'(res_got.length));
        chk("cg fetches", 20'h00000, 20'(fa.size()));
        $display("done immediate");
    endtask

    task automatic t_abs();
        oam_req_s r;
        for (int e = 0; e < 2; e++) begin
            r = base();
            r.is_ext = e[0];
            r.src_hi = 4'h3;
            r.dst_hi = 4'h7;
            r.smode = OAM_S_ABS;
            r.dmode = OAM_D_ABS;
            r.size = e ? OAM_SZ_A : OAM_SZ_W;
            r.op_idx = 5'h1A;
            fq = '{16'h579C, 16'h7778};
            rq = '{16'h1234};
            if (e) rq.push_back(16'h0005);
            run(r, 1'b1, 20'hABCDE);
            chk("src addr", {e ? 4'h3 : 4'h0, 16'h579C}, res_got.src_addr);
            chk("dst addr", {e ? 4'h7 : 4'h0, 16'h7778}, res_got.dst_addr);
            chk("src data", e ? 20'h51234 : 20'h01234, res_got.src_data);
            chk("length", e ? 20'h00004 : 20'h00003, 20'(res_got.length));
            chk("pc step", r.pc + 20'h00004, pc_got);
            chk("mem ops", e ? 20'h00004 : 20'h00002, 20'(ma.size()));
        end
        chk("rd addr1", 20'h3579E, ma[1][35:16]);
        chk("wr addr0", 20'h77778, ma[2][35:16]);
        chk("wr data0", 20'h0BCDE, {4'h0, ma[2][15:0]});
        chk("wr addr1", 20'h7777A, ma[3][35:16]);
        chk("wr data1", 20'h0000A, {4'h0, ma[3][15:0]});
        chk("we flags", 20'h1, 20'({ma[1][36], ma[3][36]}));
        $display("done absolute");
    endtask

    task automatic t_ind();
        oam_req_s r;
        r = base();
        r.smode = OAM_S_IND;
        r.dmode = OAM_D_IDX;
        r.src_reg = 4'h5;
        r.dst_reg = 4'h6;
        r.src_ptr = 20'h3579C;
        r.dst_ptr = 20'h45678;
        fq = '{16'h2100};
        rq = '{16'h1234};
        run(r, 1'b1, 20'h0CAFE);
        chk("rd addr", 20'h3579C, ma[0][35:16]);
        chk("src data", 20'h01234, res_got.src_data);
        chk("ptr writes", 20'h00000, 20'(n_reg));
        chk("dst addr", 20'h47778, res_got.dst_addr);
        chk("wr addr", 20'h47778, ma[1][35:16]);
        chk("wr data", 20'h0CAFE, {4'h0, ma[1][15:0]});
        chk("dst mem", 20'h1, 20'(res_got.dst_mem));
        $display("done indirect");
    endtask

    task automatic t_ainc();
        oam_req_s r;
        oam_addr_t stp;
        for (int s = 0; s < 3; s++) begin
            r = base();
            r.smode = OAM_S_AINC;
            r.dmode = OAM_D_IDX;
            r.src_reg = 4'h5;
            r.dst_reg = 4'h5;
            r.size = oam_size_e'(s);
            r.is_ext = (s == 2);
            r.src_ptr = 20'h8579C;
            r.dst_ptr = 20'h8579C;
            stp = (s == 0) ? 20'h00001 : (s == 1) ? 20'h00002 : 20'h00004;
            fq = '{16'h0000};
            rq = '{16'h1234};
            if (s == 2) rq.push_back(16'h0005);
            run(r, 1'b1, 20'h00000);
            chk("rd addr", 20'h8579C, ma[0][35:16]);
            chk("ptr next", 20'h8579C + stp, reg_got);
            chk("ptr writes", 20'h00001, 20'(n_reg));
            chk("dst addr", 20'h8579C + stp, res_got.dst_addr);
            chk("length", (s == 2) ? 20'h00003 : 20'h00002, 20'(res_got.length));
        end
        $display("done autoincrement");
    endtask

    task automatic t_bad();
        oam_req_s r;
        for (int k = 0; k < 4; k++) begin
            r = base();
            r.smode = OAM_S_IND;
            r.dmode = (k == 0) ? OAM_D_IND : OAM_D_REG;
            r.op_idx = (k == 1) ? 5'h1B : (k == 2) ? 5'h1F : 5'h1A;
            rq = '{16'h0001};
            run(r, 1'b0, 20'h00000);
            chk("illegal", {19'h0, k < 3}, {19'h0, res_got.illegal});
            chk("mem ops", (k < 3) ? 20'h00000 : 20'h00001, 20'(ma.size()));
        end
        $display("done illegal");
    endtask

    // ----------------
    // main sequence and watchdog
    // ----------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_imm();
        t_abs();
        t_ind();
        t_ainc();
        t_bad();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end
endmodule // oam_operand_gen_tb_top
